// >>> hw/exec_tail.sv
`timescale 1ns/1ns
module exec_tail #(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // instruction issue
   input exec_tail_pkg::issue_s issue,
   // table pointers and program page
   input wire logic [7:0] table_pointer_low,
   input wire logic [7:0] table_pointer_high,
   input wire logic [7:0] current_page,
   // program code read port, combinational answer
   output logic [ADDR_W-1:0] code_addr,
   input wire logic [15:0] code_word,
   // results
   output exec_tail_pkg::mem_wr_s mem_wr,
   output logic [7:0] acc,
   output exec_tail_pkg::flags_s flags,
   output logic [7:0] table_high_latch,
   output logic skip_taken
);
   import exec_tail_pkg::*;

   //--------------------------------------------------------------
   // state
   //--------------------------------------------------------------
   logic [7:0] acc_reg, acc_next;
   flags_s flags_reg, flags_next;
   mem_wr_s mem_wr_reg, mem_wr_next;
   logic [7:0] tbl_reg, tbl_next;
   logic skip_reg, skip_next;
   logic [ADDR_W-1:0] code_addr_reg;

   function automatic logic [7:0] nib_swap(input logic [7:0] v);
      return {v[3:0], v[7:4]};
   endfunction : nib_swap

   function automatic logic is_null(input logic [7:0] v);
      return v == BYTE_ZERO;
   endfunction : is_null

   //--------------------------------------------------------------
   // decode and datapath
   //--------------------------------------------------------------
   wire logic squash;
   wire logic live;
   op_e op;
   wire logic [7:0] m;
   wire logic [7:0] sel_mask;
   wire logic sel_bit;
   wire logic [7:0] dec_v;
   wire logic [7:0] inc_v;
   wire logic use_imm;
   wire logic use_borrow;
   wire logic [7:0] sub_b;
   wire logic [7:0] sub_d;
   flags_s sub_f;

   assign live = issue.valid & ~squash;
   assign op = op_e'(issue.opcode);
   assign m = issue.mem_operand;
   assign sel_mask = BYTE_ONE << issue.bit_sel;
   assign sel_bit = m[issue.bit_sel];
   assign dec_v = m - BYTE_ONE;
   assign inc_v = m + BYTE_ONE;
   assign use_imm = (op == op_minus_imm);
   assign use_borrow = (op == op_sub_borrow_to_memory);
   assign sub_b = use_imm ? issue.immediate : m;

   sub_unit u_sub (
      .minuend(acc_reg),
      .subtrahend(sub_b),
      .borrow_in(use_borrow & ~flags_reg.borrow_out_flag),
      .diff(sub_d),
      .flags(sub_f)
   );

   skip_ctrl u_skip (
      .clk(clk),
      .rst_n(rst_n),
      .skip_req(skip_next),
      .squash(squash)
   );

   // table addresses
   wire logic [ADDR_W-1:0] addr_paged;
   wire logic [ADDR_W-1:0] addr_cur;
   wire logic [ADDR_W-1:0] addr_last;
   assign addr_paged = ADDR_W'({table_pointer_high, table_pointer_low});
   assign addr_cur = ADDR_W'({current_page, table_pointer_low});
   assign addr_last = {{(ADDR_W-PAGE_W){1'b1}}, table_pointer_low};

   always_comb begin
      acc_next = acc_reg;
      flags_next = flags_reg;
      mem_wr_next = '{we: 1'b0, data: mem_wr_reg.data};
      tbl_next = tbl_reg;
      skip_next = 1'b0;
      if (live) begin
         case (op)
            op_sub_borrow_to_memory, op_minus_to_memory: begin
               mem_wr_next = '{we: 1'b1, data: sub_d};
               flags_next = sub_f;
            end
            op_minus_to_acc, op_minus_imm: begin
               acc_next = sub_d;
               flags_next = sub_f;
            end
            op_dec_skip_zero: begin
               mem_wr_next = '{we: 1'b1, data: dec_v};
               skip_next = is_null(dec_v);
            end
            op_dec_skip_zero_to_acc: begin
               acc_next = dec_v;
               skip_next = is_null(dec_v);
            end
            op_set_byte: mem_wr_next = '{we: 1'b1, data: ALL_ONES};
            op_set_bit: mem_wr_next = '{we: 1'b1, data: m | sel_mask};
            op_inc_skip_zero: begin
               mem_wr_next = '{we: 1'b1, data: inc_v};
               skip_next = is_null(inc_v);
            end
            op_inc_skip_zero_to_acc: begin
               acc_next = inc_v;
               skip_next = is_null(inc_v);
            end
            op_bit_skip_set: skip_next = sel_bit;
            op_bit_skip_clear: skip_next = ~sel_bit;
            op_nibble_exchange:
               mem_wr_next = '{we: 1'b1, data: nib_swap(m)};
            op_nibble_exchange_to_acc: acc_next = nib_swap(m);
            op_skip_if_null: skip_next = is_null(m);
            op_copy_skip_if_null: begin
               acc_next = m;
               skip_next = is_null(m);
            end
            op_table_read_paged, op_table_read_current,
            op_table_read_last: begin
               mem_wr_next = '{we: 1'b1, data: code_word[7:0]};
               tbl_next = code_word[15:8];
            end
            op_xor_to_acc: begin
               acc_next = acc_reg ^ m;
               flags_next.result_null_flag = is_null(acc_reg ^ m);
            end
            op_xor_imm: begin
               acc_next = acc_reg ^ issue.immediate;
               flags_next.result_null_flag =
                  is_null(acc_reg ^ issue.immediate);
            end
            op_xor_to_memory: begin
               mem_wr_next = '{we: 1'b1, data: acc_reg ^ m};
               flags_next.result_null_flag = is_null(acc_reg ^ m);
            end
            default: ;
         endcase
      end
   end

   // code address presented in the same cycle as the table read
   wire logic [ADDR_W-1:0] code_addr_sel;
   assign code_addr_sel =
      (op == op_table_read_paged) ? addr_paged :
      (op == op_table_read_current) ? addr_cur :
      (op == op_table_read_last) ? addr_last :
      code_addr_reg;

   //--------------------------------------------------------------
   // registers
   //--------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc_reg <= ACC_RESET;
         flags_reg <= FLAG_RESET;
         mem_wr_reg <= '0;
         tbl_reg <= TBL_RESET;
         skip_reg <= 1'b0;
         code_addr_reg <= '0;
      end else begin
         acc_reg <= acc_next;
         flags_reg <= flags_next;
         mem_wr_reg <= mem_wr_next;
         tbl_reg <= tbl_next;
         skip_reg <= skip_next;
         code_addr_reg <= code_addr_sel;
      end
   end

   assign code_addr = code_addr_sel;
   assign acc = acc_reg;
   assign flags = flags_reg;
   assign mem_wr = mem_wr_reg;
   assign table_high_latch = tbl_reg;
   assign skip_taken = skip_reg;

   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------
   sequence skip_then_dummy;
      skip_next ##1 (skip_reg && !mem_wr_next.we);
   endsequence
   sequence slot_squashed;
      skip_reg && !live;
   endsequence
   sequence state_held;
      !mem_wr.we && $stable(acc) && $stable(flags)
         && $stable(table_high_latch);
   endsequence
   sequence two_cycle_skip;
      skip_taken ##1 !skip_taken;
   endsequence

   skip_squash_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      skip_next |=> slot_squashed ##1 state_held)
      else $error("skipped slot modified state");
   skip_dummy_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      skip_next |-> skip_then_dummy)
      else $error("skip did not insert dummy cycle");
   borrow_flag_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_minus_to_acc |=>
         flags.borrow_out_flag == ($past(acc_reg) >= $past(m)))
      else $error("borrow flag wrong");
   set_byte_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_set_byte |=>
         mem_wr.we && mem_wr.data == ALL_ONES && $stable(flags))
      else $error("set byte wrong");
   dec_skip_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_dec_skip_zero && m == BYTE_ONE |=>
         (mem_wr.we && mem_wr.data == BYTE_ZERO && $stable(flags))
         ##0 two_cycle_skip)
      else $error("decrement skip wrong");
   set_bit_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_set_bit |=> mem_wr.we && $stable(flags)
         && mem_wr.data == ($past(m) | (BYTE_ONE << $past(issue.bit_sel))))
      else $error("set bit wrong");
   inc_mem_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_inc_skip_zero |=> mem_wr.we && $stable(flags)
         && mem_wr.data == $past(m) + BYTE_ONE
         && skip_taken == (mem_wr.data == BYTE_ZERO))
      else $error("increment skip wrong");
   inc_acc_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_inc_skip_zero_to_acc |=>
         acc == $past(m) + BYTE_ONE && !mem_wr.we
         && skip_taken == (acc == BYTE_ZERO))
      else $error("increment to acc wrong");
   bit_set_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_bit_skip_set |=>
         skip_taken == $past(m[issue.bit_sel]) && !mem_wr.we)
      else $error("bit set skip wrong");
   bit_clear_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_bit_skip_clear |=>
         skip_taken == !$past(m[issue.bit_sel]) && !mem_wr.we)
      else $error("bit clear skip wrong");
   sub_acc_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_minus_to_acc |=>
         acc == $past(acc) - $past(m) && !mem_wr.we)
      else $error("subtract to acc wrong");
   sub_mem_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_minus_to_memory |=> mem_wr.we && $stable(acc)
         && mem_wr.data == $past(acc) - $past(m))
      else $error("subtract to memory wrong");
   sbc_mem_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_sub_borrow_to_memory |=> mem_wr.we
         && mem_wr.data == $past(acc) - $past(m)
            - {7'h00, !$past(flags.borrow_out_flag)})
      else $error("subtract with borrow wrong");
   swap_mem_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_nibble_exchange |=>
         mem_wr.data == {$past(m[3:0]), $past(m[7:4])} && $stable(flags))
      else $error("nibble swap wrong");
   null_skip_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_skip_if_null |=> !mem_wr.we && $stable(acc)
         && skip_taken == ($past(m) == BYTE_ZERO))
      else $error("zero skip wrong");
   copy_skip_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_copy_skip_if_null |=> acc == $past(m)
         && skip_taken == (acc == BYTE_ZERO) && $stable(flags))
      else $error("copy skip wrong");
   tbl_latch_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_table_read_paged |=> mem_wr.we
         && mem_wr.data == $past(code_word[7:0])
         && table_high_latch == $past(code_word[15:8]))
      else $error("table latch wrong");
   xor_flag_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      live && op == op_xor_to_acc |=> $stable(flags.borrow_out_flag)
         && flags.result_null_flag == (acc == BYTE_ZERO))
      else $error("xor flags wrong");
endmodule : exec_tail

// >>> hw/exec_tail_pkg.sv
package exec_tail_pkg;
   localparam int DATA_W = 8;
   localparam int CODE_W = 16;
   localparam int PAGE_W = 8;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] TBL_RESET = 8'h00;
   localparam logic [3:0] FLAG_RESET = 4'h0;
   localparam int SKIP_CYCLES = 2;

   typedef enum {
      op_nop, op_sub_borrow_to_memory, op_dec_skip_zero,
      op_dec_skip_zero_to_acc, op_set_byte, op_set_bit,
      op_inc_skip_zero, op_inc_skip_zero_to_acc, op_bit_skip_set,
      op_minus_to_acc, op_minus_to_memory, op_minus_imm,
      op_nibble_exchange, op_nibble_exchange_to_acc, op_skip_if_null,
      op_copy_skip_if_null, op_bit_skip_clear, op_table_read_paged,
      op_table_read_current, op_table_read_last, op_xor_to_acc,
      op_xor_to_memory, op_xor_imm
   } op_e;

   // arithmetic flags of the status byte
   typedef struct packed {
      logic signed_wrap_flag;
      logic result_null_flag;
      logic nibble_carry_flag;
      logic borrow_out_flag;
   } flags_s;

   // one instruction issued to the execute stage
   typedef struct packed {
      logic valid;
      logic [4:0] opcode;
      logic [7:0] mem_operand;
      logic [7:0] immediate;
      logic [2:0] bit_sel;
   } issue_s;

   // memory write-back request
   typedef struct packed {
      logic we;
      logic [7:0] data;
   } mem_wr_s;
endpackage : exec_tail_pkg

// >>> hw/skip_ctrl.sv
`timescale 1ns/1ns
module skip_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic skip_req,
   output logic squash
);
   import exec_tail_pkg::*;
   logic squash_reg;
   // squash the next issued slot when a skip was taken
   always_ff @(posedge clk) begin
      if (!rst_n) squash_reg <= 1'b0;
      else squash_reg <= skip_req;
   end
   assign squash = squash_reg;
endmodule : skip_ctrl

// >>> hw/sub_unit.sv
`timescale 1ns/1ns
module sub_unit (
   // operands
   input wire logic [7:0] minuend,
   input wire logic [7:0] subtrahend,
   input wire logic borrow_in,
   // result
   output logic [7:0] diff,
   output exec_tail_pkg::flags_s flags
);
   import exec_tail_pkg::*;
   wire logic [8:0] wide;
   wire logic [4:0] low;
   assign wide = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
   assign low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]}
      - {4'h0, borrow_in};
   assign diff = wide[7:0];
   // carry set means no borrow
   assign flags.borrow_out_flag = ~wide[8];
   assign flags.nibble_carry_flag = ~low[4];
   assign flags.result_null_flag = (wide[7:0] == BYTE_ZERO);
   assign flags.signed_wrap_flag = (minuend[7] ^ subtrahend[7])
      & (minuend[7] ^ wide[7]);
endmodule : sub_unit

// >>> test/test_mcu_instruction_execute_tail.sv
`timescale 1ns/1ns
module test_mcu_instruction_execute_tail;
   import exec_tail_pkg::*;
   // ---------------------------------------------------------------
   // bench signals
   // ---------------------------------------------------------------
   logic clk;
   logic rst_n;
   issue_s issue;
   logic [7:0] table_pointer_low;
   logic [7:0] table_pointer_high;
   logic [7:0] current_page;
   logic [15:0] code_addr;
   logic [15:0] code_word;
   mem_wr_s mem_wr;
   logic [7:0] acc;
   flags_s flags;
   logic [7:0] table_high_latch;
   logic skip_taken;
   int err_total;
   int check_count;
   logic [7:0] acc_m;
   flags_s flg_m;

   exec_tail #(.ADDR_W(16)) u_dut (
      .clk(clk), .rst_n(rst_n), .issue(issue),
      .table_pointer_low(table_pointer_low),
      .table_pointer_high(table_pointer_high),
      .current_page(current_page), .code_addr(code_addr),
      .code_word(code_word), .mem_wr(mem_wr), .acc(acc), .flags(flags),
      .table_high_latch(table_high_latch), .skip_taken(skip_taken)
   );

   // code store: low byte shows the page, high byte the inverted offset
   assign code_word = {~code_addr[7:0], code_addr[15:8]};

   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] e,
      input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   // returns {wrap, null, nibble, borrow_out, difference}
   function automatic logic [11:0] sub(input logic [7:0] a,
      input logic [7:0] b, input logic cin);
      logic [8:0] t;
      logic [4:0] n;
      t = {1'h0, a} - {1'h0, b} - {8'h0, !cin};
      n = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, !cin};
      return {(a[7] ^ b[7]) & (a[7] ^ t[7]), t[7:0] == 8'h00, !n[4],
         !t[8], t[7:0]};
   endfunction : sub

   // issue one op, then judge the answer one cycle later
   task automatic go(input op_e op, input logic [7:0] m,
      input logic [7:0] imm, input logic [2:0] bs, input logic we,
      input logic [7:0] d, input logic sk);
      issue = '{1'h1, 5'(op), m, imm, bs};
      @(posedge clk);
      #1;
      chk("mem_we", {7'h0, we}, {7'h0, mem_wr.we});
      if (we) chk("mem_data", d, mem_wr.data);
      chk("acc", acc_m, acc);
      chk("flags", {4'h0, flg_m}, {4'h0, flags});
      chk("skip", {7'h0, sk}, {7'h0, skip_taken});
   endtask : go

   // skip op followed by a set byte that must vanish when skipped
   task automatic sk(input op_e op, input logic [7:0] m,
      input logic [2:0] bs, input logic we, input logic [7:0] d,
      input logic wa, input logic s);
      if (wa) acc_m = d;
      go(op, m, 8'h00, bs, we, d, s);
      go(op_set_byte, 8'h00, 8'h00, 3'h0, !s, ALL_ONES, 1'h0);
   endtask : sk

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_sub();
      logic [7:0] a[5] = '{8'h50, 8'h30, 8'h80, 8'h12, 8'h10};
      logic [7:0] b[5] = '{8'h30, 8'h50, 8'h01, 8'h12, 8'h01};
      op_e ops[4] = '{op_minus_to_acc, op_minus_to_memory, op_minus_imm,
         op_sub_borrow_to_memory};
      logic [11:0] r;
      logic im;
      logic tm;
      foreach (ops[k]) begin
         foreach (a[i]) begin
            im = ops[k] == op_minus_imm;
            tm = ops[k] == op_minus_to_memory ||
               ops[k] == op_sub_borrow_to_memory;
            acc_m = a[i];
            go(op_copy_skip_if_null, a[i], 8'h00, 3'h0, 1'h0, 8'h00,
               1'h0);
            r = sub(a[i], b[i], ops[k] == op_sub_borrow_to_memory ?
               flg_m.borrow_out_flag : 1'h1);
            flg_m = r[11:8];
            if (!tm) acc_m = r[7:0];
            go(ops[k], im ? ~b[i] : b[i], im ? b[i] : ~b[i], 3'h0, tm,
               r[7:0], 1'h0);
         end
      end
      $display("test subtract done");
   endtask : t_sub

   task automatic t_skip();
      sk(op_dec_skip_zero, 8'h01, 3'h0, 1'h1, 8'h00, 1'h0, 1'h1);
      sk(op_dec_skip_zero, 8'h00, 3'h0, 1'h1, 8'hff, 1'h0, 1'h0);
      sk(op_dec_skip_zero_to_acc, 8'h01, 3'h0, 1'h0, 8'h00, 1'h1,
         1'h1);
      sk(op_dec_skip_zero_to_acc, 8'h80, 3'h0, 1'h0, 8'h7f, 1'h1,
         1'h0);
      sk(op_inc_skip_zero, 8'hff, 3'h0, 1'h1, 8'h00, 1'h0, 1'h1);
      sk(op_inc_skip_zero, 8'h7f, 3'h0, 1'h1, 8'h80, 1'h0, 1'h0);
      sk(op_inc_skip_zero_to_acc, 8'hff, 3'h0, 1'h0, 8'h00, 1'h1,
         1'h1);
      sk(op_inc_skip_zero_to_acc, 8'h00, 3'h0, 1'h0, 8'h01, 1'h1,
         1'h0);
      sk(op_bit_skip_set, 8'h08, 3'h3, 1'h0, 8'h00, 1'h0, 1'h1);
      sk(op_bit_skip_set, 8'hf7, 3'h3, 1'h0, 8'h00, 1'h0, 1'h0);
      sk(op_bit_skip_clear, 8'hf7, 3'h3, 1'h0, 8'h00, 1'h0, 1'h1);
      sk(op_bit_skip_clear, 8'h80, 3'h7, 1'h0, 8'h00, 1'h0, 1'h0);
      sk(op_skip_if_null, 8'h00, 3'h0, 1'h0, 8'h00, 1'h0, 1'h1);
      sk(op_skip_if_null, 8'h40, 3'h0, 1'h0, 8'h00, 1'h0, 1'h0);
      sk(op_copy_skip_if_null, 8'h00, 3'h0, 1'h0, 8'h00, 1'h1,
         1'h1);
      $display("test skip done");
   endtask : t_skip

   task automatic t_bits();
      go(op_set_byte, 8'h5a, 8'h00, 3'h0, 1'h1, ALL_ONES, 1'h0);
      for (int i = 0; i < 8; i++) begin
         go(op_set_bit, 8'ha5, 8'h00, 3'(i), 1'h1, 8'ha5 | 8'(1 << i),
            1'h0);
      end
      go(op_nibble_exchange, 8'h3c, 8'h00, 3'h0, 1'h1, 8'hc3,
         1'h0);
      acc_m = 8'h1e;
      go(op_nibble_exchange_to_acc, 8'he1, 8'h00, 3'h0, 1'h0, 8'h00,
         1'h0);
      acc_m = 8'h00;
      flg_m.result_null_flag = 1'h1;
      go(op_xor_to_acc, 8'h1e, 8'h00, 3'h0, 1'h0, 8'h00, 1'h0);
      acc_m = 8'h33;
      flg_m.result_null_flag = 1'h0;
      go(op_xor_imm, 8'hcc, 8'h33, 3'h0, 1'h0, 8'h00, 1'h0);
      flg_m.result_null_flag = 1'h1;
      go(op_xor_to_memory, 8'h33, 8'h00, 3'h0, 1'h1, 8'h00, 1'h0);
      flg_m.result_null_flag = 1'h0;
      go(op_xor_to_memory, 8'h0f, 8'h00, 3'h0, 1'h1, 8'h3c, 1'h0);
      $display("test bits done");
   endtask : t_bits

   task automatic t_table();
      table_pointer_high = 8'h12;
      current_page = 8'h56;
      table_pointer_low = 8'h34;
      go(op_table_read_paged, 8'h00, 8'h00, 3'h0, 1'h1, 8'h12,
         1'h0);
      chk("latch", 8'hcb, table_high_latch);
      table_pointer_low = 8'h35;
      go(op_table_read_current, 8'h00, 8'h00, 3'h0, 1'h1, 8'h56,
         1'h0);
      chk("latch", 8'hca, table_high_latch);
      table_pointer_low = 8'h36;
      go(op_table_read_last, 8'h00, 8'h00, 3'h0, 1'h1, 8'hff,
         1'h0);
      chk("latch", 8'hc9, table_high_latch);
      $display("test table done");
   endtask : t_table

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      #1_000_000;
      err_total++;
      summarize();
   end

   initial begin
      issue = '0;
      table_pointer_low = 8'h00;
      table_pointer_high = 8'h00;
      current_page = 8'h00;
      rst_n = 1'h0;
      err_total = 0;
      check_count = 0;
      acc_m = ACC_RESET;
      flg_m = FLAG_RESET;
      repeat (8) @(posedge clk);
      #1;
      chk("acc", ACC_RESET, acc);
      chk("flags", {4'h0, FLAG_RESET}, {4'h0, flags});
      chk("latch", TBL_RESET, table_high_latch);
      chk("skip", 8'h00, {7'h0, skip_taken});
      rst_n = 1'h1;
      t_sub();
      t_skip();
      t_bits();
      t_table();
      summarize();
   end
endmodule : test_mcu_instruction_execute_tail
